/* include/gate_pkg.sv */
// Package for the output gate and pad configuration block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package gate_pkg;
   // Register byte addresses
   localparam logic [11:0] ADDR_OUTPUT_GATE_CONFIG = 12'h000;
   localparam logic [11:0] ADDR_PAD_MISC_CONFIG = 12'h004;
   localparam logic [11:0] ADDR_GATE_STATUS = 12'h008;
   // output_gate_config fields
   localparam int GATE_SEL_BIT = 0;
   localparam int GATE_POL_BIT = 3;
   localparam int GATE_PU_BIT = 4;
   localparam int GATE_PD_BIT = 5;
   localparam logic [7:0] OUTPUT_GATE_RST = 8'h10;
   localparam logic [7:0] OUTPUT_GATE_WMASK = 8'h39;
   // pad_misc_config fields
   localparam int HOLD_LSB = 6;
   localparam int PP_LSB = 4;
   localparam int OD_LSB = 2;
   localparam int SERIAL_DATA_PULLUP_EN_BIT = 1;
   localparam int SERIAL_CLOCK_PULLUP_EN_BIT = 0;
   localparam logic [7:0] PAD_MISC_RST = 8'h2f;
   // Startup hold codes
   localparam logic [1:0] HOLD_APLL = 2'h0;
   localparam logic [1:0] HOLD_DPLL = 2'h1;
   localparam logic [1:0] HOLD_NONE = 2'h2;
   localparam logic [1:0] HOLD_RSVD = 2'h3;
   // Gate select codes
   localparam logic GATE_BY_PIN = 1'h0;
   localparam logic GATE_IGNORE = 1'h1;
endpackage : gate_pkg

/* include/gate_cfg_if.sv */
// Interface carrying gate settings from register file to gate logic.
// Assumes one clock domain.
`timescale 1ns/100ps
`default_nettype none
interface gate_cfg_if;
   logic gate_sel;
   logic gate_pol;
   logic [1:0] hold_code;
   logic drivers_en;
   logic hold_released;
   modport regs (output gate_sel, gate_pol, hold_code, input drivers_en, hold_released);
   modport gate (input gate_sel, gate_pol, hold_code, output drivers_en, hold_released);
endinterface : gate_cfg_if
`default_nettype wire

/* verilog/output_gate.sv */
// Combines the startup lock hold and the enable pin gate.
// Assumes pin and lock inputs synchronous to core_clk_i.
`timescale 1ns/100ps
`default_nettype none
module output_gate (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Pin and lock status
   input wire logic oe_pin_i,
   input wire logic apll_lock_i,
   input wire logic dpll_lock_i,
   // Settings
   gate_cfg_if.gate cfg
);
   logic released_q;
   logic pin_ok;

   ////////////////////////////////////////////////////////////////////////
   // Startup hold, released once and kept
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         released_q <= 1'b0;
      end else if (!released_q) begin
         unique case (cfg.hold_code)
            gate_pkg::HOLD_APLL: released_q <= apll_lock_i;
            gate_pkg::HOLD_DPLL: released_q <= dpll_lock_i;
            gate_pkg::HOLD_NONE: released_q <= 1'b1;
            default: released_q <= 1'b0;
         endcase
      end
   end

   // Pin gate with polarity
   assign pin_ok = (cfg.gate_sel == gate_pkg::GATE_IGNORE)
      || (oe_pin_i ^ cfg.gate_pol);
   assign cfg.drivers_en = released_q && pin_ok;
   assign cfg.hold_released = released_q;

   ////////////////////////////////////////////////////////////////////////
   a_pin_disables: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!cfg.gate_sel && (oe_pin_i == cfg.gate_pol)) |-> !cfg.drivers_en)
      else $error("Pin de-asserted but drivers enabled");
   a_pin_ignored: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cfg.gate_sel && released_q) |-> cfg.drivers_en)
      else $error("Ignored pin still gates drivers");
   a_pol_enable: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!cfg.gate_sel && released_q && (oe_pin_i != cfg.gate_pol)) |-> cfg.drivers_en)
      else $error("Pin asserted but drivers off");
   a_apll_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!released_q && cfg.hold_code == gate_pkg::HOLD_APLL && apll_lock_i)
      |=> released_q)
      else $error("APLL lock did not release hold");
   a_dpll_wait: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (!released_q && cfg.hold_code == gate_pkg::HOLD_DPLL && !dpll_lock_i)
      |=> !released_q)
      else $error("Hold released without DPLL lock");
   a_no_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (cfg.hold_code == gate_pkg::HOLD_NONE) |=> released_q)
      else $error("Hold code two still holds");
   a_both_gates: assert property (@(posedge core_clk_i) disable iff (rst_i)
      cfg.drivers_en |-> (released_q && pin_ok))
      else $error("Drivers on without both gates");
   c_pin_gating: cover property (@(posedge core_clk_i) disable iff (rst_i)
      cfg.drivers_en ##1 !cfg.drivers_en);
   c_release: cover property (@(posedge core_clk_i) disable iff (rst_i)
      !released_q ##1 released_q);
endmodule : output_gate
`default_nettype wire

/* verilog/gate_pad_config.sv */
// Output gate and pad configuration block with APB register access.
// Assumes APB master on core_clk_i; pin and lock inputs synchronous.
`timescale 1ns/100ps
`default_nettype none
module gate_pad_config (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Pin and lock status
   input wire logic oe_pin_i,
   input wire logic apll_lock_i,
   input wire logic dpll_lock_i,
   // Clock driver enable
   output logic clk_drivers_en_o,
   // Pad settings
   output logic gate_pin_pullup_en_o,
   output logic gate_pin_pulldown_en_o,
   output logic [1:0] pushpull_strength_o,
   output logic [1:0] opendrain_strength_o,
   output logic serial_data_pullup_en_o,
   output logic serial_clock_pullup_en_o
);
   logic [7:0] output_gate_config_q;
   logic [7:0] pad_misc_config_q;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [31:0] rdata_d;

   gate_cfg_if cfg ();

   ////////////////////////////////////////////////////////////////////////
   // APB decode, zero wait states
   assign pready_o = 1'b1;
   assign addr_ok = (paddr_i == gate_pkg::ADDR_OUTPUT_GATE_CONFIG)
      || (paddr_i == gate_pkg::ADDR_PAD_MISC_CONFIG)
      || (paddr_i == gate_pkg::ADDR_GATE_STATUS);
   assign pslverr_o = psel_i && penable_i && !addr_ok;
   assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0];
   assign rd_en = psel_i && penable_i && !pwrite_i;

   ////////////////////////////////////////////////////////////////////////
   // Output gate register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         output_gate_config_q <= gate_pkg::OUTPUT_GATE_RST;
      end else if (wr_en && paddr_i == gate_pkg::ADDR_OUTPUT_GATE_CONFIG) begin
         output_gate_config_q <= pwdata_i[7:0] & gate_pkg::OUTPUT_GATE_WMASK;
      end
   end

   // Pad misc register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pad_misc_config_q <= gate_pkg::PAD_MISC_RST;
      end else if (wr_en && paddr_i == gate_pkg::ADDR_PAD_MISC_CONFIG) begin
         pad_misc_config_q <= pwdata_i[7:0];
      end
   end

   // Read data
   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (paddr_i)
         gate_pkg::ADDR_OUTPUT_GATE_CONFIG: rdata_d[7:0] = output_gate_config_q;
         gate_pkg::ADDR_PAD_MISC_CONFIG: rdata_d[7:0] = pad_misc_config_q;
         gate_pkg::ADDR_GATE_STATUS: rdata_d[1:0] = {cfg.hold_released, cfg.drivers_en};
         default: rdata_d = 32'h0000_0000;
      endcase
   end
   assign prdata_o = rd_en ? rdata_d : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Settings to gate logic
   assign cfg.gate_sel = output_gate_config_q[gate_pkg::GATE_SEL_BIT];
   assign cfg.gate_pol = output_gate_config_q[gate_pkg::GATE_POL_BIT];
   assign cfg.hold_code = pad_misc_config_q[gate_pkg::HOLD_LSB +: 2];

   output_gate u_gate (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .oe_pin_i(oe_pin_i),
      .apll_lock_i(apll_lock_i),
      .dpll_lock_i(dpll_lock_i),
      .cfg(cfg.gate)
   );

   // Pad outputs
   assign clk_drivers_en_o = cfg.drivers_en;
   assign gate_pin_pullup_en_o = output_gate_config_q[gate_pkg::GATE_PU_BIT];
   assign gate_pin_pulldown_en_o = output_gate_config_q[gate_pkg::GATE_PD_BIT];
   assign pushpull_strength_o = pad_misc_config_q[gate_pkg::PP_LSB +: 2];
   assign opendrain_strength_o = pad_misc_config_q[gate_pkg::OD_LSB +: 2];
   assign serial_data_pullup_en_o = pad_misc_config_q[gate_pkg::SERIAL_DATA_PULLUP_EN_BIT];
   assign serial_clock_pullup_en_o = pad_misc_config_q[gate_pkg::SERIAL_CLOCK_PULLUP_EN_BIT];

   ////////////////////////////////////////////////////////////////////////
   a_pad_reset: assert property (@(posedge core_clk_i)
      $fell(rst_i) |-> (pushpull_strength_o == 2'h2 && opendrain_strength_o == 2'h3))
      else $error("Strength reset values wrong");
   a_hold_reset: assert property (@(posedge core_clk_i)
      $fell(rst_i) |-> (cfg.hold_code == 2'h0 && gate_pin_pullup_en_o
      && !gate_pin_pulldown_en_o))
      else $error("Hold or gate pin pull reset wrong");
   a_serial_pull: assert property (@(posedge core_clk_i)
      $fell(rst_i) |-> (serial_data_pullup_en_o && serial_clock_pullup_en_o))
      else $error("Serial pull-ups not set after reset");
   a_pp_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_en && paddr_i == gate_pkg::ADDR_PAD_MISC_CONFIG)
      |=> pushpull_strength_o == $past(pwdata_i[5:4]) && opendrain_strength_o == $past(pwdata_i[3:2]))
      else $error("Strength write not applied");
   a_pd_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (wr_en && paddr_i == gate_pkg::ADDR_OUTPUT_GATE_CONFIG)
      |=> gate_pin_pulldown_en_o == $past(pwdata_i[5]))
      else $error("Pull-down write not applied");
   c_gate_write: cover property (@(posedge core_clk_i) disable iff (rst_i)
      wr_en && paddr_i == gate_pkg::ADDR_OUTPUT_GATE_CONFIG);
   c_status_read: cover property (@(posedge core_clk_i) disable iff (rst_i)
      rd_en && paddr_i == gate_pkg::ADDR_GATE_STATUS && clk_drivers_en_o);
endmodule : gate_pad_config
`default_nettype wire

/* verification/oe_board_model.sv */
// Board logic that drives or releases the enable pin.
// Assumes one clock shared with the block.
`timescale 1ns/100ps
`default_nettype none
module oe_board_model (
   // Clock
   input wire logic clk_i,
   // Drive request
   input wire logic drive_en_i,
   input wire logic drive_val_i,
   // Pad pulls from the block
   input wire logic pullup_en_i,
   input wire logic pulldown_en_i,
   // Pin level
   output logic pin_o
);
   logic toggle_q = 1'b0;
   always_ff @(posedge clk_i) toggle_q <= ~toggle_q;
   always_comb begin
      if (drive_en_i) pin_o = drive_val_i;
      else if (pullup_en_i) pin_o = 1'b1;
      else if (pulldown_en_i) pin_o = 1'b0;
      else pin_o = toggle_q;
   end
endmodule : oe_board_model
`default_nettype wire

/* verification/gate_pad_config_tb_top.sv */
// Testbench for the output gate and pad configuration block.
// Assumes zero-wait APB slave and the board model beside it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module gate_pad_config_tb_top;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, den = 0, dval = 0, apll = 0, dpll = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, pin, en, pu, pd, sdpu, scpu, e;
   logic [1:0] pp, od;
   int n_fail = 0, n_checks = 0;
   initial forever #10 clk = ~clk;
   gate_pad_config uut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .oe_pin_i(pin),
      .apll_lock_i(apll), .dpll_lock_i(dpll), .clk_drivers_en_o(en),
      .gate_pin_pullup_en_o(pu), .gate_pin_pulldown_en_o(pd), .pushpull_strength_o(pp),
      .opendrain_strength_o(od), .serial_data_pullup_en_o(sdpu),
      .serial_clock_pullup_en_o(scpu));
   oe_board_model board (.clk_i(clk), .drive_en_i(den), .drive_val_i(dval),
      .pullup_en_i(pu), .pulldown_en_i(pd), .pin_o(pin));
   ////////////////////////////////////////////////////////////////
   task final_report;
      if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clk);
      psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1;
      @(negedge clk);
      while (pready !== 1'b1) begin
         i++;
         if (i > 20) begin n_fail++; final_report; end
         @(negedge clk);
      end
      r = prdata; e = pslverr;
      @(posedge clk);
      psel <= 0; pen <= 0;
   endtask : apb
   task do_reset;
      @(posedge clk);
      rst <= 1; apll <= 0; dpll <= 0; den <= 0;
      repeat (3) @(posedge clk);
      rst <= 0;
   endtask : do_reset
   task pin_set(input logic de, input logic dv, input logic exp);
      @(posedge clk);
      den <= de; dval <= dv;
      @(posedge clk); #1;
      `CHK(en, exp)
   endtask : pin_set
   task locks(input logic a, input logic d, input logic exp);
      @(posedge clk);
      apll <= a; dpll <= d;
      repeat (3) @(posedge clk); #1;
      `CHK(en, exp)
   endtask : locks
   ////////////////////////////////////////////////////////////////
   task t_reset_values;
      apb(0, 12'h000, 0); `CHK(r, 32'h10)
      apb(0, 12'h004, 0); `CHK(r, 32'h2f)
      `CHK({pu, pd, pp, od, sdpu, scpu}, 8'haf)
      locks(0, 1, 0);
      locks(1, 1, 1);
   endtask : t_reset_values
   task t_pin_gate;
      pin_set(1, 0, 0);
      pin_set(1, 1, 1);
      apb(1, 12'h000, 32'h18);
      pin_set(1, 1, 0);
      pin_set(1, 0, 1);
      apb(1, 12'h000, 32'h19);
      pin_set(1, 1, 1);
      pin_set(1, 0, 1);
      apb(1, 12'h000, 32'h20);
      pin_set(0, 0, 0);
      apb(1, 12'h000, 32'hff);
      apb(0, 12'h000, 0); `CHK(r, 32'h39)
      apb(0, 12'h00c, 0); `CHK(e, 1'b1)
      apb(1, 12'h004, 32'h04); #1;
      `CHK({pp, od, sdpu, scpu}, 6'h04)
   endtask : t_pin_gate
   task t_hold_codes;
      do_reset;
      apb(1, 12'h004, 32'h6b);
      locks(1, 0, 0);
      locks(1, 1, 1);
      do_reset;
      apb(1, 12'h004, 32'hab);
      locks(0, 0, 1);
      do_reset;
      apb(0, 12'h004, 0); `CHK(r[7:6], 2'h0)
   endtask : t_hold_codes
   initial begin
      do_reset;
      t_reset_values;
      t_pin_gate;
      t_hold_codes;
      final_report;
   end
endmodule : gate_pad_config_tb_top
`default_nettype wire
